/* File: hdl/servo_status_outputs.v */
`include "servo_status_consts.vh"

module servo_status_outputs #(
    parameter MS_CYCLES = `CYCLES_PER_MS
) (
    input  wire        ref_clk_in,
    input  wire        reset_in,
    input  wire [2:0]  control_mode_in,
    input  wire [31:0] position_error_in,
    input  wire [31:0] motor_position_in,
    input  wire [31:0] target_position_in,
    input  wire [31:0] in_position_window_in,
    input  wire [15:0] motor_torque_in,
    input  wire [15:0] torque_limit_settings_in,
    input  wire [15:0] analog_torque_limit_in,
    input  wire        analog_limit_enable_in,
    input  wire        fault_other_in,
    input  wire        fault_caution_class_in,
    input  wire        servo_on_state_in,
    input  wire [15:0] motor_speed_in,
    input  wire [15:0] zero_speed_threshold_in,
    input  wire [15:0] brake_release_delay_in,
    input  wire [15:0] brake_engage_delay_in,
    input  wire        origin_sensor_input_in,
    input  wire        homing_active_in,
    input  wire        homing_trigger_in,
    input  wire        position_overflow_in,
    input  wire [7:0]  pin_select0_in,
    input  wire [7:0]  pin_select1_in,
    output reg         position_reached_flag_out,
    output reg         torque_limit_flag_out,
    output reg         fault_alarm_flag_out,
    output reg         caution_flag_out,
    output reg         brake_drive_output_out,
    output reg         homing_done_flag_out,
    output reg  [1:0]  config_pin_out
);

    localparam BRK_ENGAGED   = 2'h0;
    localparam BRK_RELEASING = 2'h1;
    localparam BRK_RELEASED  = 2'h2;
    localparam BRK_ENGAGING  = 2'h3;
    localparam NUM_PINS      = 2;
    localparam [31:0] MS_LAST = MS_CYCLES - 1;

    reg  [1:0]            brake_state;
    reg  [1:0]            next_brake_state;
    reg                   next_brake;
    reg                   brake_restart;
    reg  [31:0]           brake_count;
    reg  [15:0]           brake_ms;
    reg  [15:0]           caution_count;
    reg  [15:0]           next_caution_count;
    reg                   origin_seen;
    reg                   next_origin_seen;
    reg                   homing_active_prev;
    reg                   homing_done_event;
    reg  [31:0]           pos_diff;
    reg  [31:0]           pos_abs;
    reg  [15:0]           eff_limit;
    reg                   torque_mode;
    reg                   next_reached;
    reg                   next_torque;
    reg                   next_caution;
    reg                   next_alarm;
    reg                   next_home;
    wire                  ms_tick;
    wire [8*NUM_PINS-1:0] pin_select_all;
    wire [NUM_PINS-1:0]   next_pins;

    assign ms_tick        = (brake_count >= MS_LAST);
    assign pin_select_all = {pin_select1_in, pin_select0_in};

    // Register-mode positions are signed, so the distance to the target is folded to a magnitude.
    always @* begin
        pos_diff = motor_position_in - target_position_in;
        if (pos_diff[31]) begin
            pos_abs = 32'h00000000 - pos_diff;
        end else begin
            pos_abs = pos_diff;
        end
    end

    // The analog limit only tightens the parameter limit; it never raises it.
    always @* begin
        eff_limit = torque_limit_settings_in;
        if (analog_limit_enable_in && (analog_torque_limit_in < torque_limit_settings_in)) begin
            eff_limit = analog_torque_limit_in;
        end
    end

    always @* begin
        case (control_mode_in)
            `MODE_TORQUE:      torque_mode = 1'b1;
            `MODE_TORQUE_ZERO: torque_mode = 1'b1;
            default:           torque_mode = 1'b0;
        endcase
    end

    always @* begin
        case (control_mode_in)
            `MODE_EXT_PULSE_POS: next_reached = (position_error_in <= in_position_window_in); // RULE1
            `MODE_INT_REG_POS:   next_reached = (pos_abs <= in_position_window_in); // RULE2
            default:             next_reached = 1'b0;
        endcase
    end

    always @* begin
        next_torque = 1'b0;
        if (!torque_mode && (motor_torque_in >= eff_limit)) begin
            next_torque = 1'b1; // RULE3
        end
    end

    always @* begin
        next_caution = fault_caution_class_in; // RULE5
    end

    // Listed faults hold the alarm off until the caution flag has led it.
    always @* begin
        next_caution_count = caution_count;
        if (!fault_caution_class_in) begin
            next_caution_count = 16'h0000;
        end else if (caution_count < `CAUTION_LEAD_CYCLES) begin
            next_caution_count = caution_count + 16'h0001;
        end
    end

    always @* begin
        next_alarm = 1'b0;
        if (fault_other_in) begin
            next_alarm = 1'b1; // RULE4
        end else if (fault_caution_class_in && (caution_count >= `CAUTION_LEAD_CYCLES)) begin
            next_alarm = 1'b1; // RULE5
        end
    end

    // The origin sensor only counts while a homing run is active.
    always @* begin
        next_origin_seen = origin_seen;
        if (homing_trigger_in) begin
            next_origin_seen = 1'b0;
        end else if (origin_sensor_input_in && homing_active_in) begin
            next_origin_seen = 1'b1;
        end
    end

    always @* begin
        homing_done_event = 1'b0;
        if ((control_mode_in == `MODE_INT_REG_POS) && homing_active_prev && !homing_active_in && origin_seen) begin
            homing_done_event = 1'b1;
        end
    end

    // A new homing run or an overflow outranks a completion in the same cycle.
    always @* begin
        next_home = homing_done_flag_out;
        if (position_overflow_in) begin
            next_home = 1'b0; // RULE9
        end else if (homing_trigger_in) begin
            next_home = 1'b0; // RULE10
        end else if (homing_done_event) begin
            next_home = 1'b1; // RULE7
        end
    end

    // Each configurable pin picks one status level by its selection code.
    genvar pin;
    generate
        for (pin = 0; pin < NUM_PINS; pin = pin + 1) begin : g_pin
            wire [7:0] sel;
            reg        level;
            assign sel = pin_select_all[8*pin +: 8];
            always @* begin
                case (sel)
                    `SEL_POS_REACHED:  level = position_reached_flag_out;
                    `SEL_TORQUE_LIMIT: level = torque_limit_flag_out;
                    `SEL_FAULT_ALARM:  level = fault_alarm_flag_out;
                    `SEL_BRAKE:        level = brake_drive_output_out;
                    `SEL_HOME_DONE:    level = homing_done_flag_out;
                    default:           level = 1'b0;
                endcase
            end
            assign next_pins[pin] = level;
        end
    endgenerate

    // Every flag is recomputed each clock and held as a level.
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            position_reached_flag_out <= 1'b0;
            torque_limit_flag_out     <= 1'b0;
        end else begin
            position_reached_flag_out <= next_reached; // RULE11
            torque_limit_flag_out     <= next_torque;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            caution_flag_out     <= 1'b0;
            fault_alarm_flag_out <= 1'b0;
        end else begin
            caution_flag_out     <= next_caution;
            fault_alarm_flag_out <= next_alarm;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            caution_count <= 16'h0000;
        end else begin
            caution_count <= next_caution_count;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            homing_done_flag_out <= 1'b0; // RULE8
            origin_seen          <= 1'b0;
            homing_active_prev   <= 1'b0;
        end else begin
            homing_done_flag_out <= next_home;
            origin_seen          <= next_origin_seen;
            homing_active_prev   <= homing_active_in;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            config_pin_out <= 2'h0;
        end else begin
            config_pin_out <= next_pins;
        end
    end

    // Brake output high means the brake is released; delays are in milliseconds.
    always @* begin
        next_brake_state = brake_state;
        next_brake       = brake_drive_output_out;
        brake_restart    = 1'b0;
        case (brake_state)
            BRK_ENGAGED: begin
                next_brake = 1'b0;
                if (servo_on_state_in) begin
                    next_brake_state = BRK_RELEASING;
                    brake_restart    = 1'b1;
                end
            end
            BRK_RELEASING: begin
                if (!servo_on_state_in) begin
                    next_brake_state = BRK_ENGAGED;
                end else if (brake_ms >= brake_release_delay_in) begin
                    next_brake_state = BRK_RELEASED; // RULE12
                    next_brake       = 1'b1; // RULE6
                end
            end
            BRK_RELEASED: begin
                if (!servo_on_state_in) begin
                    next_brake_state = BRK_ENGAGING;
                    brake_restart    = 1'b1;
                end
            end
            BRK_ENGAGING: begin
                if (servo_on_state_in) begin
                    next_brake_state = BRK_RELEASED;
                end else if ((brake_ms >= brake_engage_delay_in) || (motor_speed_in <= zero_speed_threshold_in)) begin
                    next_brake_state = BRK_ENGAGED; // RULE12
                    next_brake       = 1'b0; // RULE6
                end
            end
            default: begin
                next_brake_state = BRK_ENGAGED;
                next_brake       = 1'b0;
            end
        endcase
    end

    // The millisecond count saturates so a long wait cannot wrap back below its setting.
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            brake_count <= 32'h00000000;
            brake_ms    <= 16'h0000;
        end else if (brake_restart) begin
            brake_count <= 32'h00000000;
            brake_ms    <= 16'h0000;
        end else if (ms_tick) begin
            brake_count <= 32'h00000000;
            if (brake_ms != 16'hFFFF) begin
                brake_ms <= brake_ms + 16'h0001;
            end
        end else begin
            brake_count <= brake_count + 32'h00000001;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            brake_state            <= BRK_ENGAGED;
            brake_drive_output_out <= 1'b0;
        end else begin
            brake_state            <= next_brake_state;
            brake_drive_output_out <= next_brake;
        end
    end

endmodule // servo_status_outputs

/* File: hdl/servo_status_consts.vh */
// Functional notes
// RULE1: Pulse mode: reached when error within window.
// RULE2: Register mode: reached within plus/minus window.
// RULE3: Torque-limit flag, except in torque modes.
// RULE4: Fault alarm on any fault, all modes.
// RULE5: Caution flag precedes alarm for listed faults.
// RULE6: Brake output actuates holding brake with delays.
// RULE7: Homing-done after origin sensor, register mode.
// RULE8: Homing-done low after power-up until homing.
// RULE9: Homing-done held; cleared by overflow or new homing.
// RULE10: New register homing clears flag immediately.
// RULE11: Outputs are steady levels, evaluated every cycle.
// RULE12: Release after delay; engage on delay or speed.
`ifndef SERVO_STATUS_CONSTS_VH
`define SERVO_STATUS_CONSTS_VH
`define MODE_EXT_PULSE_POS  3'h0
`define MODE_INT_REG_POS    3'h1
`define MODE_SPEED          3'h2
`define MODE_TORQUE         3'h3
`define MODE_TORQUE_ZERO    3'h4
`define SEL_POS_REACHED     8'h05
`define SEL_TORQUE_LIMIT    8'h06
`define SEL_FAULT_ALARM     8'h07
`define SEL_BRAKE           8'h08
`define SEL_HOME_DONE       8'h09
`define CLK_PERIOD_NS       20
`define DELAY_UNIT_NS       1000000
`define CYCLES_PER_MS       (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define CAUTION_LEAD_CYCLES 16'h0004
`endif

/* File: testbench/servo_status_outputs_chk.sv */
`include "servo_status_consts.vh"
module servo_status_chk (
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    input wire logic [2:0]  control_mode_in,
    input wire logic [31:0] position_error_in,
    input wire logic [31:0] in_position_window_in,
    input wire logic        fault_other_in,
    input wire logic        fault_caution_class_in,
    input wire logic        origin_sensor_input_in,
    input wire logic        homing_active_in,
    input wire logic        homing_trigger_in,
    input wire logic        position_overflow_in,
    input wire logic        position_reached_flag_out,
    input wire logic        fault_alarm_flag_out,
    input wire logic        caution_flag_out,
    input wire logic        homing_done_flag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    logic org_seen;
    logic active_q;
    wire  run_end = active_q && !homing_active_in;
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || homing_trigger_in) org_seen <= 1'b0;
        else if (origin_sensor_input_in && homing_active_in) org_seen <= 1'b1;
    end
    always_ff @(posedge ref_clk_in) begin
        active_q <= homing_active_in;
    end
    wire in_win = position_error_in <= in_position_window_in;
    sequence s_caution_held; fault_caution_class_in [*5]; endsequence
    sequence s_homing_end; $fell(homing_active_in) && control_mode_in == `MODE_INT_REG_POS; endsequence
    property p_pulse_pos; control_mode_in == `MODE_EXT_PULSE_POS |=> position_reached_flag_out == $past(in_win);
    endproperty
    property p_fault; fault_other_in |=> fault_alarm_flag_out; endproperty
    property p_caution_first;
        $rose(fault_caution_class_in) && !fault_other_in |=> caution_flag_out && !fault_alarm_flag_out;
    endproperty
    property p_caution_alarm; s_caution_held |=> fault_alarm_flag_out; endproperty
    property p_home_set;
        s_homing_end ##0 (org_seen && !homing_trigger_in && !position_overflow_in) |=> homing_done_flag_out;
    endproperty
    property p_home_after_run; $rose(homing_done_flag_out) |-> $past(run_end); endproperty
    property p_home_reset; $fell(reset_in) |-> !homing_done_flag_out; endproperty
    property p_home_hold;
        homing_done_flag_out && !position_overflow_in && !homing_trigger_in |=> homing_done_flag_out;
    endproperty
    property p_home_clear; homing_trigger_in || position_overflow_in |=> !homing_done_flag_out; endproperty
    a_pulse_pos: assert property (p_pulse_pos) else $error("pulse mode window flag wrong");
    a_fault: assert property (p_fault) else $error("alarm missing on fault");
    a_caution_first: assert property (p_caution_first) else $error("caution not first");
    a_caution_alarm: assert property (p_caution_alarm) else $error("alarm late after caution");
    a_home_set: assert property (p_home_set) else $error("homing done not set");
    a_home_reset: assert property (p_home_reset) else $error("homing done set after reset");
    a_home_after_run: assert property (p_home_after_run) else $error("homing done without a finished run");
    a_home_hold: assert property (p_home_hold) else $error("homing done dropped");
    a_home_clear: assert property (p_home_clear) else $error("homing done not cleared");
endmodule // servo_status_chk
bind servo_status_outputs servo_status_chk i_chk (
    .ref_clk_in                (ref_clk_in),
    .reset_in                  (reset_in),
    .control_mode_in           (control_mode_in),
    .position_error_in         (position_error_in),
    .in_position_window_in     (in_position_window_in),
    .fault_other_in            (fault_other_in),
    .fault_caution_class_in    (fault_caution_class_in),
    .origin_sensor_input_in    (origin_sensor_input_in),
    .homing_active_in          (homing_active_in),
    .homing_trigger_in         (homing_trigger_in),
    .position_overflow_in      (position_overflow_in),
    .position_reached_flag_out (position_reached_flag_out),
    .fault_alarm_flag_out      (fault_alarm_flag_out),
    .caution_flag_out          (caution_flag_out),
    .homing_done_flag_out      (homing_done_flag_out)
);

/* File: testbench/status_reader.sv */
module status_reader (
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] config_pin_out,
    output logic      [1:0] pins_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge ref_clk_in) pins_seen <= config_pin_out;
endmodule // status_reader

/* File: testbench/tb.sv */
`include "servo_status_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_in = 1'b0, reset_in = 1'b1, analog_limit_enable_in = 1'b0, fault_other_in = 1'b0;
    logic        fault_caution_class_in = 1'b0, servo_on_state_in = 1'b0, origin_sensor_input_in = 1'b0;
    logic        homing_active_in = 1'b0, homing_trigger_in = 1'b0, position_overflow_in = 1'b0;
    logic [2:0]  control_mode_in = 3'h0;
    logic [31:0] position_error_in = 32'h0, motor_position_in = 32'h0, target_position_in = 32'h64;
    logic [31:0] in_position_window_in = 32'h0A;
    logic [15:0] motor_torque_in = 16'h32, torque_limit_settings_in = 16'h32, analog_torque_limit_in = 16'h31;
    logic [15:0] motor_speed_in = 16'h64, zero_speed_threshold_in = 16'h5;
    logic [15:0] brake_release_delay_in = 16'h1, brake_engage_delay_in = 16'h3;
    logic [7:0]  pin_select0_in = `SEL_FAULT_ALARM, pin_select1_in = `SEL_HOME_DONE;
    logic [31:0] mp [4] = '{32'h59, 32'h5A, 32'h6E, 32'h6F};
    wire         position_reached_flag_out, torque_limit_flag_out, fault_alarm_flag_out, caution_flag_out;
    wire         brake_drive_output_out, homing_done_flag_out;
    wire  [1:0]  config_pin_out, pins_seen;
    int          n_mismatch = 0, n_compared = 0, i;
    servo_status_outputs #(
        .MS_CYCLES(4)
    ) i_dut (
        .ref_clk_in                (ref_clk_in),
        .reset_in                  (reset_in),
        .control_mode_in           (control_mode_in),
        .position_error_in         (position_error_in),
        .motor_position_in         (motor_position_in),
        .target_position_in        (target_position_in),
        .in_position_window_in     (in_position_window_in),
        .motor_torque_in           (motor_torque_in),
        .torque_limit_settings_in  (torque_limit_settings_in),
        .analog_torque_limit_in    (analog_torque_limit_in),
        .analog_limit_enable_in    (analog_limit_enable_in),
        .fault_other_in            (fault_other_in),
        .fault_caution_class_in    (fault_caution_class_in),
        .servo_on_state_in         (servo_on_state_in),
        .motor_speed_in            (motor_speed_in),
        .zero_speed_threshold_in   (zero_speed_threshold_in),
        .brake_release_delay_in    (brake_release_delay_in),
        .brake_engage_delay_in     (brake_engage_delay_in),
        .origin_sensor_input_in    (origin_sensor_input_in),
        .homing_active_in          (homing_active_in),
        .homing_trigger_in         (homing_trigger_in),
        .position_overflow_in      (position_overflow_in),
        .pin_select0_in            (pin_select0_in),
        .pin_select1_in            (pin_select1_in),
        .position_reached_flag_out (position_reached_flag_out),
        .torque_limit_flag_out     (torque_limit_flag_out),
        .fault_alarm_flag_out      (fault_alarm_flag_out),
        .caution_flag_out          (caution_flag_out),
        .brake_drive_output_out    (brake_drive_output_out),
        .homing_done_flag_out      (homing_done_flag_out),
        .config_pin_out            (config_pin_out)
    );
    status_reader i_reader (
        .ref_clk_in     (ref_clk_in),
        .config_pin_out (config_pin_out),
        .pins_seen      (pins_seen)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        cyc(16);
        reset_in <= 1'b0;
        look(1);
        chk(homing_done_flag_out, 1'b0);
        for (i = 0; i < 8; i++) begin
            cyc(1);
            control_mode_in <= {2'b00, i[2]};
            position_error_in <= 32'h09 + i[1:0];
            motor_position_in <= mp[i[1:0]];
            look(2);
            chk(position_reached_flag_out, i[2] ? (i[0] ^ i[1]) : !i[1]);
        end
        $display("test position done");
        for (i = 4; i >= 0; i--) begin
            cyc(1);
            control_mode_in <= i[2:0];
            look(2);
            chk(torque_limit_flag_out, i < 3);
        end
        cyc(1);
        motor_torque_in <= 16'h31;
        analog_limit_enable_in <= 1'b1;
        look(2);
        chk(torque_limit_flag_out, 1'b1);
        $display("test torque done");
        cyc(1);
        fault_other_in <= 1'b1;
        look(2);
        chk(fault_alarm_flag_out, 1'b1);
        cyc(1);
        fault_other_in <= 1'b0;
        fault_caution_class_in <= 1'b1;
        look(2);
        chk({caution_flag_out, fault_alarm_flag_out}, 2'b10);
        look(5);
        chk(fault_alarm_flag_out, 1'b1);
        cyc(1);
        fault_caution_class_in <= 1'b0;
        servo_on_state_in <= 1'b1;
        look(1);
        chk(brake_drive_output_out, 1'b0);
        for (i = 0; i < 40 && brake_drive_output_out !== 1'b1; i++) look(1);
        chk(brake_drive_output_out, 1'b1);
        if (i == 40) end_of_test();
        cyc(1);
        servo_on_state_in <= 1'b0;
        look(2);
        chk(brake_drive_output_out, 1'b1);
        cyc(1);
        motor_speed_in <= 16'h0;
        look(2);
        chk(brake_drive_output_out, 1'b0);
        $display("test fault and brake done");
        cyc(1);
        control_mode_in <= `MODE_INT_REG_POS;
        homing_active_in <= 1'b1;
        origin_sensor_input_in <= 1'b1;
        look(2);
        chk(homing_done_flag_out, 1'b0);
        for (i = 0; i < 2; i++) begin
            cyc(1);
            homing_active_in <= 1'b0;
            motor_speed_in <= 16'h64;
            look(8);
            chk(homing_done_flag_out, 1'b1);
            chk(pins_seen, 2'b10);
            cyc(1);
            homing_trigger_in <= !i[0];
            homing_active_in <= 1'b1;
            position_overflow_in <= i[0];
            cyc(1);
            homing_trigger_in <= 1'b0;
            position_overflow_in <= 1'b0;
            look(1);
            chk(homing_done_flag_out, 1'b0);
        end
        $display("test homing done");
        end_of_test();
    end
endmodule // tb
